/* File: rtl/multi_queue_flags.sv */
// four-queue fifo core with composite flags, echoed read strobe and power down
`timescale 1ns/1ps
`default_nettype none
module multi_queue_flags
    import mq_flag_pkg::*;
#(
    parameter int DEPTH   = DEPTH_DEF,
    parameter int DENSITY = 0
)
(
    // clock and reset
    input  wire logic                clock,
    input  wire logic                srst,
    // device pins
    input  wire pins_t               pins,
    // per-queue flags
    output logic [QUEUES-1:0]        full_flag_n,
    output logic [QUEUES-1:0]        empty_flag_n,
    output logic [QUEUES-1:0]        almost_full_flag_n,
    output logic [QUEUES-1:0]        almost_empty_flag_n,
    // composite flags and echo
    output logic                     composite_full_flag,
    output logic                     composite_empty_flag,
    output logic                     echoed_read_strobe_n,
    output logic                     outputs_oe,
    // read data bus
    output logic [DATA_W-1:0]        read_data_bus,
    output logic                     read_data_oe,
    // serial readback
    output logic                     serial_data_out,
    output logic                     serial_data_valid
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

    // readback length for a width code and density code
    function automatic logic [RB_W-1:0] rb_bits(input logic [1:0] width);
        rb_bits = RB_W'(RB_BASE + RB_STEP * (DENSITY + int'(width)));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser, first stage feeds only the second
    pins_t meta_q;
    pins_t pin_q;
    always_ff @(posedge clock)
    begin
        meta_q <= pins;
        pin_q  <= meta_q;
    end
    ////////////////////////////////////////////////////////////////////////////
    // configuration caught once after reset, kept through power down
    logic             cfg_done_q;
    logic             fall_through_mode_q;
    logic [1:0]       width_q;
    logic [OFS_W-1:0] paf_ofs_q;
    logic [OFS_W-1:0] pae_ofs_q;
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            cfg_done_q <= 1'b0;
            fall_through_mode_q     <= 1'b0;
            width_q    <= 2'h0;
            paf_ofs_q  <= '0;
            pae_ofs_q  <= '0;
        end
        else if (!cfg_done_q)
        begin
            cfg_done_q <= 1'b1;
            fall_through_mode_q     <= pin_q.fall_through_mode;
            width_q    <= pin_q.output_width_setting;
            paf_ofs_q  <= pin_q.almost_full_offset;
            pae_ofs_q  <= pin_q.almost_empty_offset;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // power down and the wake-up wait
    logic              pd;
    logic              run;
    logic [WAIT_W-1:0] wait_q;
    assign pd  = !pin_q.power_down_input_n;
    assign run = !pd && (wait_q == '0) && cfg_done_q;
    always_ff @(posedge clock)
    begin
        if (srst)
            wait_q <= WAIT_RST;
        else if (pd)
            wait_q <= WAIT_W'(PD_WAIT_CYC);
        else if (wait_q != '0)
            wait_q <= wait_q - 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    // storage and occupancy
    logic [DATA_W-1:0] mem_q [QUEUES*DEPTH];
    logic [PTR_W-1:0]  wr_ptr_q [QUEUES];
    logic [PTR_W-1:0]  rd_ptr_q [QUEUES];
    logic [CNT_W-1:0]  cnt_q [QUEUES];
    logic [CNT_W-1:0]  cnt_d [QUEUES];
    logic [QUEUES-1:0] push;
    logic [QUEUES-1:0] pop;

    // write request stage; commit one cycle later gives the switch pipeline
    logic              wr_v_q;
    logic [1:0]        wr_sel_q;
    logic [DATA_W-1:0] wr_data_q;
    always_ff @(posedge clock)
    begin
        if (srst)
            wr_v_q <= 1'b0;
        else
            wr_v_q <= run && !pin_q.write_port_select_n && !pin_q.write_strobe_n;
        wr_sel_q  <= pin_q.input_queue_select;
        wr_data_q <= pin_q.write_data;
    end

    // read side decode on the queue selected this cycle
    logic [1:0]       rsel;
    logic             rd_en;
    logic [CNT_W-1:0] head_cnt;
    logic             new_word;
    logic             or_valid_q;
    logic [PTR_W-1:0] next_ptr;
    assign rsel     = pin_q.output_queue_select;
    assign rd_en    = run && !pin_q.read_port_select_n && !pin_q.read_strobe_n;
    assign head_cnt = cnt_q[rsel];
    assign next_ptr = rd_ptr_q[rsel] + PTR_W'(pop[rsel]);

    always_comb
    begin
        for (int i = 0; i < QUEUES; i++)
        begin
            push[i]  = wr_v_q && (wr_sel_q == 2'(i)) && (cnt_q[i] != FULL_CNT);
            pop[i]   = rd_en && (rsel == 2'(i)) && (cnt_q[i] != '0);
            cnt_d[i] = cnt_q[i] + CNT_W'(push[i]) - CNT_W'(pop[i]);
        end
        // fall-through: a word lands on a pop that leaves one behind, or when an empty view gets one
        new_word = fall_through_mode_q ? (cnt_d[rsel] != '0 && (pop[rsel] || head_cnt == '0)) : pop[rsel];
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            for (int i = 0; i < QUEUES; i++)
            begin
                wr_ptr_q[i] <= '0;
                rd_ptr_q[i] <= '0;
                cnt_q[i]    <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < QUEUES; i++)
            begin
                wr_ptr_q[i] <= wr_ptr_q[i] + PTR_W'(push[i]);
                rd_ptr_q[i] <= rd_ptr_q[i] + PTR_W'(pop[i]);
                cnt_q[i]    <= cnt_d[i];
            end
        end
    end

    // memory write, no reset needed on data
    always_ff @(posedge clock)
    begin
        if (wr_v_q && push[wr_sel_q])
            mem_q[{wr_sel_q, wr_ptr_q[wr_sel_q]}] <= wr_data_q;
    end
    ////////////////////////////////////////////////////////////////////////////
    // output register; fall-through shows the head, with bypass of a same-cycle write
    logic [DATA_W-1:0] out_q;
    logic              bypass;
    assign bypass = push[rsel] && (wr_sel_q == rsel) && (wr_ptr_q[rsel] == next_ptr);
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            out_q      <= '0;
            or_valid_q <= 1'b0;
        end
        else if (fall_through_mode_q)
        begin
            out_q      <= bypass ? wr_data_q : mem_q[{rsel, next_ptr}];
            or_valid_q <= cnt_d[rsel] != '0;
        end
        else if (pop[rsel])
            out_q <= mem_q[{rsel, rd_ptr_q[rsel]}];
    end

    // echoed strobe registered on the rising edge only
    always_ff @(posedge clock)
    begin
        if (srst)
            echoed_read_strobe_n <= FLAG_RST;
        else
            echoed_read_strobe_n <= !new_word;
    end

    // bus drive; the reader is expected to select a cycle ahead of the strobe
    always_ff @(posedge clock)
    begin
        if (srst)
            read_data_oe <= OE_RST;
        else
            read_data_oe <= run && !pin_q.read_port_select_n && !pin_q.output_enable_n;
        read_data_bus <= out_q;
    end

    // flag drive, off during power down and the wake-up wait
    always_ff @(posedge clock)
    begin
        if (srst)
            outputs_oe <= OE_RST;
        else
            outputs_oe <= run;
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-queue and composite flags; frozen while powered down
    logic [1:0] cor_sel_q;
    logic [QUEUES-1:0] full_d;
    logic [QUEUES-1:0] empty_d;
    always_comb
    begin
        for (int i = 0; i < QUEUES; i++)
        begin
            full_d[i]  = fall_through_mode_q ? (cnt_d[i] == FULL_CNT) : (cnt_d[i] != FULL_CNT);
            empty_d[i] = fall_through_mode_q ? (cnt_d[i] == '0) : (cnt_d[i] != '0);
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            full_flag_n          <= '1;
            empty_flag_n         <= '0;
            almost_full_flag_n   <= '1;
            almost_empty_flag_n  <= '0;
            composite_full_flag  <= FLAG_RST;
            composite_empty_flag <= 1'b0;
            cor_sel_q            <= 2'h0;
        end
        else if (!pd)
        begin
            cor_sel_q <= rsel;
            for (int i = 0; i < QUEUES; i++)
            begin
                full_flag_n[i]         <= full_d[i];
                empty_flag_n[i]        <= empty_d[i];
                almost_full_flag_n[i]  <= !(cnt_d[i] >= FULL_CNT - CNT_W'(paf_ofs_q));
                almost_empty_flag_n[i] <= !(cnt_d[i] <= CNT_W'(pae_ofs_q));
            end
            composite_full_flag <= full_d[pin_q.input_queue_select];
            if (fall_through_mode_q)
                composite_empty_flag <= empty_d[cor_sel_q];
            else
                composite_empty_flag <= empty_d[rsel];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // serial readback of the offsets, lsb first
    logic              ser_last_q;
    logic [RB_MAX-1:0] ser_sr_q;
    logic [RB_W-1:0]   ser_left_q;
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ser_last_q        <= 1'b1;
            ser_sr_q          <= '0;
            ser_left_q        <= '0;
            serial_data_out   <= 1'b0;
            serial_data_valid <= 1'b0;
        end
        else
        begin
            ser_last_q        <= pin_q.serial_read_n;
            serial_data_out   <= ser_sr_q[0];
            serial_data_valid <= ser_left_q != '0;
            if (run && ser_last_q && !pin_q.serial_read_n && ser_left_q == '0)
            begin
                ser_sr_q   <= RB_MAX'({4{paf_ofs_q, pae_ofs_q}});
                ser_left_q <= rb_bits(width_q);
            end
            else if (ser_left_q != '0)
            begin
                ser_sr_q   <= ser_sr_q >> 1;
                ser_left_q <= ser_left_q - 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    chk_comp_full_sel: assert property (
        !$past(pd) && !$past(srst) |-> composite_full_flag == full_flag_n[$past(pin_q.input_queue_select)])
        else $error("composite full not tracking write queue");
    chk_cef_one_cycle: assert property (
        !fall_through_mode_q && !$past(pd) && !$past(srst) |-> composite_empty_flag == empty_flag_n[$past(rsel)])
        else $error("composite empty not tracking read queue");
    chk_cor_two_cycle: assert property (
        fall_through_mode_q && !$past(pd) && !$past(pd, 2) && !$past(srst, 2)
        |-> composite_empty_flag == empty_flag_n[$past(rsel, 2)])
        else $error("composite output ready not two cycles late");
    chk_echo_std_low: assert property (
        !fall_through_mode_q && rd_en && head_cnt != '0 |=> !echoed_read_strobe_n)
        else $error("echo not low on standard read");
    chk_echo_std_high: assert property (
        !fall_through_mode_q && !rd_en |=> echoed_read_strobe_n)
        else $error("echo low without read");
    chk_echo_last_read: assert property (
        fall_through_mode_q && rd_en && head_cnt == 1 && !push[rsel] |=> echoed_read_strobe_n && empty_flag_n[$past(rsel)])
        else $error("read past last word not flagged");
    chk_data_oe_cause: assert property (
        read_data_oe |-> $past(!pin_q.read_port_select_n && !pin_q.output_enable_n))
        else $error("data bus driven without select");
    chk_pd_hiz: assert property (
        $past(pd) |-> !outputs_oe && !read_data_oe)
        else $error("outputs driven in power down");
    chk_pd_flag_hold: assert property (
        $past(pd) && !$past(srst) |-> $stable(almost_full_flag_n) && $stable(empty_flag_n) && $stable(full_flag_n))
        else $error("flags changed in power down");
    chk_pd_wake_wait: assert property (
        $fell(pd) |=> !outputs_oe [*8])
        else $error("outputs resumed too early");
    chk_paf_thresh: assert property (
        !$past(pd) && !$past(srst) |-> almost_full_flag_n[0] == !(cnt_q[0] >= FULL_CNT - CNT_W'(paf_ofs_q)))
        else $error("almost full flag wrong");
    chk_pae_thresh: assert property (
        !$past(pd) && !$past(srst) |-> almost_empty_flag_n[0] == !(cnt_q[0] <= CNT_W'(pae_ofs_q)))
        else $error("almost empty flag wrong");

    cov_queue_switch: cover property (rd_en && $changed(rsel));
    cov_fall_through: cover property (fall_through_mode_q && !or_valid_q && head_cnt == '0 && push[rsel]);
    cov_power_down:   cover property ($fell(pd) ##1 wait_q != '0);
    cov_readback:     cover property ($rose(serial_data_valid));
endmodule
`default_nettype wire

/* File: include/mq_flag_pkg.sv */
// constants and pin bundle for the four-queue flag and read-port block
package mq_flag_pkg;
    localparam int QUEUES    = 4;
    localparam int DATA_W    = 40;
    localparam int OFS_W     = 8;
    localparam int DEPTH_DEF = 16;
    // timing at the 100 MHz system clock
    localparam int CLK_NS      = 10;
    localparam int PD_WAIT_NS  = 1000;
    localparam int PD_WAIT_CYC = (PD_WAIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAIT_W      = $clog2(PD_WAIT_CYC + 1);
    // serial readback length: base for x40 at smallest density, step per width or density code
    localparam int RB_BASE = 104;
    localparam int RB_STEP = 8;
    localparam int RB_MAX  = 136;
    localparam int RB_W    = 8;
    // reset values
    localparam logic [WAIT_W-1:0] WAIT_RST = '0;
    localparam logic              FLAG_RST = 1'b1;
    localparam logic              OE_RST   = 1'b0;

    // every input pin of the device, synchronised together
    typedef struct packed {
        logic              write_strobe_n;
        logic              write_port_select_n;
        logic [1:0]        input_queue_select;
        logic [DATA_W-1:0] write_data;
        logic              read_strobe_n;
        logic              read_port_select_n;
        logic              output_enable_n;
        logic [1:0]        output_queue_select;
        logic              fall_through_mode;
        logic [1:0]        output_width_setting;
        logic [OFS_W-1:0]  almost_full_offset;
        logic [OFS_W-1:0]  almost_empty_offset;
        logic              power_down_input_n;
        logic              serial_read_n;
    } pins_t;
endpackage

/* File: verif/stream_partner.sv */
// partner model: upstream writer and downstream reader driving the device pins
`timescale 1ns/1ps
`default_nettype none
module stream_partner
    import mq_flag_pkg::*;
(
    // clock
    input  wire logic clock,
    // device pins
    output var  pins_t pins
);
    // idle levels: both ports selected long before any strobe, output enabled
    initial
    begin
        pins = '0;
        pins.write_strobe_n      = 1'b1;
        pins.read_strobe_n       = 1'b1;
        pins.power_down_input_n  = 1'b1;
        pins.serial_read_n       = 1'b1;
        pins.almost_full_offset  = 8'h04;
        pins.almost_empty_offset = 8'h02;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one word per call; strobe stays low when calls follow back to back
    task automatic wr(input logic [1:0] q, input logic [DATA_W-1:0] d);
        @(posedge clock);
        pins.write_strobe_n     <= 1'b0;
        pins.input_queue_select <= q;
        pins.write_data         <= d;
    endtask

    task automatic rd(input logic [1:0] q);
        @(posedge clock);
        pins.read_strobe_n       <= 1'b0;
        pins.output_queue_select <= q;
    endtask

    // data turned over so a stale word never looks like a fresh one
    task automatic idle();
        @(posedge clock);
        pins.write_strobe_n <= 1'b1;
        pins.read_strobe_n  <= 1'b1;
        pins.write_data     <= ~pins.write_data;
    endtask

    task automatic drive(input pins_t v);
        @(posedge clock);
        pins <= v;
    endtask

    // traffic stopped four cycles before power down
    task automatic sleep();
        repeat (4) idle();
        @(posedge clock);
        pins.power_down_input_n <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: verif/multi_queue_flag_echo_powerdown_bench.sv */
// self-checking bench for the four-queue flag and read-port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module multi_queue_flag_echo_powerdown_bench;
    import mq_flag_pkg::*;
    localparam int DEPTH = 16;
    logic              clock;
    logic              srst;
    pins_t             pins;
    pins_t             p;
    logic [QUEUES-1:0] full_flag_n;
    logic [QUEUES-1:0] empty_flag_n;
    logic [QUEUES-1:0] almost_full_flag_n;
    logic [QUEUES-1:0] almost_empty_flag_n;
    logic              composite_full_flag;
    logic              composite_empty_flag;
    logic              echoed_read_strobe_n;
    logic              outputs_oe;
    logic [DATA_W-1:0] read_data_bus;
    logic              read_data_oe;
    logic              serial_data_out;
    logic              serial_data_valid;
    int                error_cnt = 0;
    int                total_checks = 0;
    int                n;
    int                m;
    logic [15:0]       sbits;

    multi_queue_flags #(.DEPTH(DEPTH), .DENSITY(0)) u_multi_queue_flags (
        .clock(clock), .srst(srst), .pins(pins),
        .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
        .almost_full_flag_n(almost_full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
        .composite_full_flag(composite_full_flag), .composite_empty_flag(composite_empty_flag),
        .echoed_read_strobe_n(echoed_read_strobe_n), .outputs_oe(outputs_oe),
        .read_data_bus(read_data_bus), .read_data_oe(read_data_oe),
        .serial_data_out(serial_data_out), .serial_data_valid(serial_data_valid)
    );
    stream_partner u_stream_partner (.clock(clock), .pins(pins));

    // 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs are sampled on the falling edge, clear of the update edge
    task automatic cyc(input int k);
        repeat (k) @(negedge clock);
    endtask

    // echo pulses over the window one transfer can cause
    task automatic ewait(input int exp);
        n = 0;
        repeat (10)
        begin
            @(negedge clock);
            if (echoed_read_strobe_n !== 1'b1) n++;
        end
        `CHK(n, exp)
    endtask

    task automatic get(input logic [1:0] q, input logic [DATA_W-1:0] d);
        u_stream_partner.rd(q);
        u_stream_partner.idle();
        ewait(1);
        `CHK(read_data_bus, d)
    endtask

    task automatic flags(input int q, input int c);
        cyc(4);
        `CHK(empty_flag_n[q], c != 0)
        `CHK(full_flag_n[q], c != DEPTH)
        `CHK(almost_full_flag_n[q], c < DEPTH - 4)
        `CHK(almost_empty_flag_n[q], c > 2)
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // watchdog, far beyond the thousand or so cycles the tests take
    initial
    begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        srst = 1'b1;
        repeat (10) @(posedge clock);
        `CHK(full_flag_n, 4'hf)
        `CHK(outputs_oe, 1'b0)
        srst <= 1'b0;
        cyc(4);
        // queue switch on every write cycle
        u_stream_partner.wr(0, 40'ha0);
        u_stream_partner.wr(3, 40'hb0);
        u_stream_partner.wr(0, 40'ha1);
        u_stream_partner.wr(3, 40'hb1);
        u_stream_partner.idle();
        cyc(4);
        get(0, 40'ha0);
        get(0, 40'ha1);
        get(3, 40'hb0);
        get(3, 40'hb1);
        u_stream_partner.rd(3);
        u_stream_partner.idle();
        ewait(0);
        // fill one queue across both almost thresholds, then one refused word
        for (int k = 1; k <= DEPTH + 1; k++)
        begin
            u_stream_partner.wr(1, 40'h10 + k);
            u_stream_partner.idle();
            flags(1, (k > DEPTH) ? DEPTH : k);
        end
        // composite flags follow the selection one cycle after it is seen
        p = pins;
        p.output_queue_select = 2'h1;
        u_stream_partner.drive(p);
        cyc(4);
        `CHK(composite_full_flag, 1'b0)
        `CHK(composite_empty_flag, 1'b1)
        p.output_queue_select = 2'h2;
        p.input_queue_select = 2'h0;
        u_stream_partner.drive(p);
        cyc(3);
        `CHK(composite_empty_flag, 1'b1)
        `CHK(composite_full_flag, 1'b0)
        cyc(1);
        `CHK(composite_empty_flag, 1'b0)
        `CHK(composite_full_flag, 1'b1)
        // bus drive needs both select and output enable
        p.output_enable_n = 1'b1;
        u_stream_partner.drive(p);
        cyc(4);
        `CHK(read_data_oe, 1'b0)
        p.output_enable_n = 1'b0;
        p.read_port_select_n = 1'b1;
        u_stream_partner.drive(p);
        u_stream_partner.rd(1);
        u_stream_partner.idle();
        ewait(0);
        `CHK(read_data_oe, 1'b0)
        p = pins;
        p.read_port_select_n = 1'b0;
        u_stream_partner.drive(p);
        cyc(4);
        `CHK(read_data_oe, 1'b1)
        // power down with a full queue: flags frozen, outputs released
        u_stream_partner.sleep();
        cyc(4);
        `CHK(outputs_oe, 1'b0)
        `CHK(read_data_oe, 1'b0)
        `CHK(full_flag_n[1], 1'b0)
        `CHK(empty_flag_n[1], 1'b1)
        // a readback request while asleep must be ignored
        p = pins;
        p.serial_read_n = 1'b0;
        u_stream_partner.drive(p);
        cyc(6);
        `CHK(serial_data_valid, 1'b0)
        p.serial_read_n = 1'b1;
        p.power_down_input_n = 1'b1;
        u_stream_partner.drive(p);
        m = 0;
        while (outputs_oe !== 1'b1 && m < 300)
        begin
            cyc(1);
            m++;
        end
        `CHK(m >= PD_WAIT_CYC && m <= PD_WAIT_CYC + 6, 1'b1)
        flags(1, DEPTH);
        // drain: words in order, almost-full released on the way down
        for (int k = 1; k <= DEPTH; k++)
        begin
            get(1, 40'h10 + k);
            flags(1, DEPTH - k);
        end
        // serial readback length for x40 at the smallest density
        p = pins;
        p.serial_read_n = 1'b0;
        u_stream_partner.drive(p);
        m = 0;
        sbits = '0;
        repeat (300)
        begin
            cyc(1);
            if (serial_data_valid === 1'b1)
            begin
                if (m < 16)
                    sbits[m] = serial_data_out;
                m++;
            end
        end
        `CHK(m, 104)
        `CHK(sbits, 16'h0402)
        // fall-through mode, taken at reset
        p.serial_read_n = 1'b1;
        p.fall_through_mode = 1'b1;
        p.output_queue_select = 2'h2;
        u_stream_partner.drive(p);
        @(posedge clock);
        srst <= 1'b1;
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        cyc(4);
        `CHK(full_flag_n, 4'h0)
        `CHK(composite_full_flag, 1'b0)
        u_stream_partner.wr(2, 40'hc0);
        u_stream_partner.wr(2, 40'hc1);
        u_stream_partner.idle();
        ewait(1);
        `CHK(read_data_bus, 40'hc0)
        `CHK(composite_empty_flag, 1'b0)
        get(2, 40'hc1);
        u_stream_partner.rd(2);
        u_stream_partner.idle();
        ewait(0);
        `CHK(empty_flag_n[2], 1'b1)
        `CHK(composite_empty_flag, 1'b1)
        report_and_stop();
    end
endmodule
`default_nettype wire
